// ### rtl/sqs_pkg.sv
package sqs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SQS_CLK_HZ = 10_000_000;
  localparam int SQS_TICK_MS = 10;
  localparam int SQS_TICK_CYC = SQS_CLK_HZ / 1000 * SQS_TICK_MS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SQS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SQS_GAP_OFS = 8'h04;
  localparam logic [7:0] SQS_TMO_OFS = 8'h08;
  localparam logic [7:0] SQS_RETRY_OFS = 8'h0c;
  localparam logic [7:0] SQS_RECON_OFS = 8'h10;
  localparam logic [7:0] SQS_TADDR_OFS = 8'h14;
  localparam logic [7:0] SQS_STAT_OFS = 8'h18;
  localparam logic [7:0] SQS_MASK_OFS = 8'h1c;
  localparam logic [7:0] SQS_STATE_OFS = 8'h20;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int SQS_CTRL_EN = 0;
  localparam int SQS_CTRL_TRIG = 1;
  localparam int SQS_CTRL_FBP = 2;
  localparam int SQS_CTRL_SUBP = 4;
  localparam int SQS_CTRL_CNT = 8;
  localparam int SQS_CTRL_BC = 12;
  localparam int SQS_ST_IDX = 0;
  localparam int SQS_ST_FSM = 4;
  localparam int SQS_ST_DISC = 16;
  localparam int SQS_EV_TMO = 0;
  localparam int SQS_EV_DISC = 1;
  localparam int SQS_EV_BADT = 2;
  localparam int SQS_EV_W = 3;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] SQS_CTRL_RST = 16'h0100;
  localparam logic [15:0] SQS_TIME_RST = 16'h000a;
  localparam logic [3:0] SQS_RETRY_RST = 4'h3;
  localparam logic [11:0] SQS_TADDR_RST = 12'h200;
  localparam logic [11:0] SQS_TRIG_MIN = 12'h200;
  localparam logic [1:0] SQS_POL_CLEAR = 2'h0;
  localparam logic [1:0] SQS_POL_FREEZE = 2'h1;
  localparam logic [1:0] SQS_POL_HALT = 2'h2;

  typedef enum logic [2:0] {
    SQS_IDLE, SQS_PICK, SQS_SEND, SQS_WAIT, SQS_GAP, SQS_NEXT
  } sqs_state_type;

endpackage

// ### rtl/sqs_tick_if.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// 10 ms tick carrier
// ------------------------------------------------------------------
interface sqs_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface // sqs_tick_if

`default_nettype wire

// ### rtl/sqs_tick.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// divider: one-cycle pulse every tick period
// ------------------------------------------------------------------
module sqs_tick #(
  parameter int TICK_CYCLES = 100000
) (
  input wire logic clock,
  input wire logic nrst,
  sqs_tick_if.src tk
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } sqs_tick_st_type;

  sqs_tick_st_type r, n;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("sqs_tick: TICK_CYCLES must be at least 2");
  end

  // count to period end, then pulse
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (r.cnt == 32'(TICK_CYCLES - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tk.tick = r.tick;

endmodule // sqs_tick

`default_nettype wire

// ### rtl/sqs_sched.sv
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module sqs_sched
  import sqs_pkg::*;
#(
  parameter int NODES = 4,
  parameter int DATA_W = 8,
  parameter int TICK_CYCLES = SQS_TICK_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [3:0] tx_node,
  output logic tx_bcast,
  output logic [DATA_W-1:0] tx_data,
  input wire logic [DATA_W-1:0] out_data,
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  output logic [DATA_W-1:0] host_data,
  input wire logic fb_online,
  output logic subnet_offline,
  output logic [11:0] trig_addr,
  input wire logic [7:0] trig_byte,
  output logic irq
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (NODES < 2 || NODES > 16) begin : g_bad_nodes
    $error("sqs_sched: NODES must lie in 2..16");
  end
  if (DATA_W < 1 || DATA_W > 32) begin : g_bad_data
    $error("sqs_sched: DATA_W must lie in 1..32");
  end

  localparam int IDX_W = $clog2(NODES);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sqs_state_type fsm;
    logic [3:0] idx;
    logic go;
    logic [15:0] timer;
    logic [NODES-1:0][3:0] to_cnt;
    logic [NODES-1:0] disc;
    logic [NODES-1:0][15:0] rc;
    logic [7:0] trig_last;
    logic [DATA_W-1:0] tx_data;
    logic [DATA_W-1:0] host_data;
    logic [15:0] ctrl;
    logic [15:0] gap;
    logic [15:0] tmo;
    logic [3:0] retries;
    logic [15:0] recon;
    logic [11:0] taddr;
    logic [SQS_EV_W-1:0] status;
    logic [SQS_EV_W-1:0] mask;
    logic [31:0] hrdata;
    logic a_valid;
    logic a_wr;
    logic [7:0] a_addr;
  } sqs_st_type;

  sqs_st_type r, n;

  // ----------------------------------------------------------------
  // tick divider
  // ----------------------------------------------------------------
  sqs_tick_if tk_if ();

  // every timing setting counts in these ticks
  sqs_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .nrst(nrst),
    .tk(tk_if.src)
  );

  logic tick;
  assign tick = tk_if.tick;

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  logic en, trig_mode, sub_freeze, halt, is_bc;
  logic [1:0] fb_pol;
  logic [3:0] cnt_cfg, bc_idx;
  logic [IDX_W-1:0] nid;

  assign en = r.ctrl[SQS_CTRL_EN];
  assign trig_mode = r.ctrl[SQS_CTRL_TRIG];
  assign fb_pol = r.ctrl[SQS_CTRL_FBP +: 2];
  assign sub_freeze = r.ctrl[SQS_CTRL_SUBP];
  assign cnt_cfg = r.ctrl[SQS_CTRL_CNT +: 4];
  assign bc_idx = r.ctrl[SQS_CTRL_BC +: 4];
  assign nid = r.idx[IDX_W-1:0];
  assign is_bc = (r.idx == bc_idx);
  assign halt = !fb_online && (fb_pol == SQS_POL_HALT);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [SQS_EV_W-1:0] ev;
    logic [SQS_EV_W-1:0] rd_clr;
    logic [31:0] rd;
    logic [3:0] cnt_new;
    logic [3:0] last;
    logic go;
    ev = '0;
    rd_clr = '0;
    rd = '0;
    cnt_new = '0;
    last = '0;
    go = r.go;
    n = r;

    // bus data phase: register writes
    if (r.a_valid && r.a_wr) begin
      case (r.a_addr)
        SQS_CTRL_OFS: n.ctrl = hwdata[15:0];
        SQS_GAP_OFS: n.gap = hwdata[15:0];
        SQS_TMO_OFS: n.tmo = hwdata[15:0];
        SQS_RETRY_OFS: n.retries = hwdata[3:0];
        SQS_RECON_OFS: n.recon = hwdata[15:0];
        SQS_TADDR_OFS: n.taddr = hwdata[11:0];
        SQS_MASK_OFS: n.mask = hwdata[SQS_EV_W-1:0];
        default: ;
      endcase
    end

    // bus address phase: capture, and read data into a flop
    n.a_valid = hsel && htrans[1] && hready;
    n.a_wr = hwrite;
    n.a_addr = haddr[7:0];
    if (n.a_valid && !hwrite) begin
      case (haddr[7:0])
        SQS_CTRL_OFS: rd[15:0] = r.ctrl;
        SQS_GAP_OFS: rd[15:0] = r.gap;
        SQS_TMO_OFS: rd[15:0] = r.tmo;
        SQS_RETRY_OFS: rd[3:0] = r.retries;
        SQS_RECON_OFS: rd[15:0] = r.recon;
        SQS_TADDR_OFS: rd[11:0] = r.taddr;
        SQS_STAT_OFS: begin
          rd[SQS_EV_W-1:0] = r.status;
          rd_clr = '1;
        end
        SQS_MASK_OFS: rd[SQS_EV_W-1:0] = r.mask;
        SQS_STATE_OFS: begin
          rd[SQS_ST_IDX +: 4] = r.idx;
          rd[SQS_ST_FSM +: 3] = r.fsm;
          rd[SQS_ST_DISC +: NODES] = r.disc;
        end
        default: rd = '0;
      endcase
      n.hrdata = rd;
    end

    // shared wait timer counts down on ticks
    if (tick && r.timer != 16'h0000) begin
      n.timer = r.timer - 16'h0001;
    end

    // reconnect timers of disconnected nodes
    for (int i = 0; i < NODES; i++) begin
      if (tick && r.disc[i] && r.rc[i] != 16'h0000) begin
        n.rc[i] = r.rc[i] - 16'h0001;
      end
    end

    // last list entry, bounded by the instance size
    last = (cnt_cfg == 4'h0) ? 4'h0 : cnt_cfg - 4'h1;
    if (last > 4'(NODES - 1)) begin
      last = 4'(NODES - 1);
    end

    // scheduler
    case (r.fsm)
      SQS_IDLE: begin
        if (en && !halt) begin
          n.idx = 4'h0;
          n.fsm = SQS_PICK;
        end
      end

      SQS_PICK: begin
        if (!en || halt) begin
          n.fsm = SQS_IDLE;
        end else begin
          // trigger byte sampled each time entry 0 is picked, retries of entry 0 included
          if (r.idx == 4'h0) begin
            go = 1'b1;
            if (trig_mode) begin
              go = (trig_byte != r.trig_last);
              if (r.taddr < SQS_TRIG_MIN) begin
                go = 1'b0;
                ev[SQS_EV_BADT] = 1'b1;
              end
              n.trig_last = trig_byte;
            end
            n.go = go;
          end
          if (!go) begin
            n.fsm = SQS_NEXT;
          end else if (!is_bc && r.disc[nid] && r.rc[nid] != 16'h0000) begin
            n.fsm = SQS_NEXT;
          end else begin
            // outgoing data under the fieldbus-offline policy
            if (fb_online) begin
              n.tx_data = out_data;
            end else if (fb_pol == SQS_POL_CLEAR) begin
              n.tx_data = '0;
            end else begin
              n.tx_data = r.tx_data;
            end
            n.fsm = SQS_SEND;
          end
        end
      end

      SQS_SEND: begin
        if (tx_ready) begin
          if (is_bc) begin
            n.timer = r.gap;
            n.fsm = SQS_GAP;
          end else begin
            n.timer = r.tmo;
            n.fsm = SQS_WAIT;
          end
        end
      end

      SQS_WAIT: begin
        if (rsp_valid) begin
          n.to_cnt[nid] = 4'h0;
          n.disc[nid] = 1'b0;
          n.host_data = rsp_data;
          n.fsm = SQS_NEXT;
        end else if (r.timer == 16'h0000) begin
          ev[SQS_EV_TMO] = 1'b1;
          cnt_new = r.to_cnt[nid] + 4'h1;
          if (r.disc[nid]) begin
            n.rc[nid] = r.recon;
            n.fsm = SQS_NEXT;
          end else if (cnt_new >= r.retries) begin
            n.to_cnt[nid] = cnt_new;
            n.disc[nid] = 1'b1;
            n.rc[nid] = r.recon;
            ev[SQS_EV_DISC] = 1'b1;
            if (!sub_freeze) begin
              n.host_data = '0;
            end else begin
              n.host_data = r.host_data;
            end
            n.fsm = SQS_NEXT;
          end else begin
            n.to_cnt[nid] = cnt_new;
            n.fsm = SQS_PICK;
          end
        end
      end

      SQS_GAP: begin
        if (r.timer == 16'h0000) begin
          n.fsm = SQS_NEXT;
        end
      end

      SQS_NEXT: begin
        // strict list order, wrapping to the first entry
        if (r.idx >= last) begin
          n.idx = 4'h0;
        end else begin
          n.idx = r.idx + 4'h1;
        end
        n.fsm = en ? SQS_PICK : SQS_IDLE;
      end

      default: n.fsm = SQS_IDLE;
    endcase

    // sticky events; a new event wins over the read clear
    n.status = (r.status & ~rd_clr) | ev;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
      r.fsm <= SQS_IDLE;
      r.ctrl <= SQS_CTRL_RST;
      r.gap <= SQS_TIME_RST;
      r.tmo <= SQS_TIME_RST;
      r.retries <= SQS_RETRY_RST;
      r.recon <= SQS_TIME_RST;
      r.taddr <= SQS_TADDR_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  assign hrdata = r.hrdata;
  assign tx_valid = (r.fsm == SQS_SEND);
  assign tx_node = r.idx;
  assign tx_bcast = is_bc;
  assign tx_data = r.tx_data;
  assign host_data = r.host_data;
  assign subnet_offline = |r.disc;
  assign trig_addr = r.taddr;
  assign irq = |(r.status & r.mask);

endmodule // sqs_sched

`default_nettype wire

// ### tb/sqs_sched_properties.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// port checks of the query scheduler
// ------------------------------------------------------------------
module sqs_sched_properties (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [3:0] tx_node,
  input wire logic tx_bcast,
  input wire logic [7:0] tx_data,
  input wire logic rsp_valid,
  input wire logic [7:0] host_data,
  input wire logic subnet_offline,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // bus slave never stalls and never errs
  bus_ok_a: assert property (hreadyout && !hresp) else $error("bus stall or error");
  // read data moves only after a read address phase
  read_hold_a: assert property ($past(nrst) && $changed(hrdata)
    |-> $past(hsel && htrans[1] && !hwrite && hready))
    else $error("read data moved without a read");
  // offered transaction stands until taken
  offer_hold_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_node) && $stable(tx_data)
      && $stable(tx_bcast)) else $error("offer changed before accept");
  // outgoing data is loaded only between offers
  data_load_a:
    assert property ($past(nrst) && $changed(tx_data) |-> $rose(tx_valid))
      else $error("data changed during offer");
  // entries advance one by one and wrap to zero
  node_order_a:
    assert property ($changed(tx_node) |-> tx_node == $past(tx_node) + 4'h1 || tx_node == 4'h0)
      else $error("entry order broken");
  // a broadcast is followed by a quiet gap
  bcast_gap_a:
    assert property (tx_valid && tx_ready && tx_bcast |=> !tx_valid [*8])
      else $error("no gap after broadcast");
  // a query waits before the next offer
  query_wait_a:
    assert property (tx_valid && tx_ready && !tx_bcast |=> !tx_valid [*3])
      else $error("no wait after query");
  // reported data moves on a response or a clear
  host_update_a:
    assert property ($changed(host_data) |-> host_data == 8'h00 || $past(rsp_valid)
      || $past(rsp_valid, 2)) else $error("reported data moved alone");
  // reset leaves the outputs quiet
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !tx_valid && host_data == 8'h00
    && !irq && !subnet_offline) else $error("outputs busy after reset");
endmodule // sqs_sched_properties

`default_nettype wire

// ### tb/sqs_slave_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// slave nodes: accept offers, answer queries
// ------------------------------------------------------------------
module sqs_slave_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic tx_valid,
  input wire logic [3:0] tx_node,
  input wire logic tx_bcast,
  input wire logic [7:0] tx_data,
  input wire logic slow,
  input wire logic [3:0] mute,
  output logic tx_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  logic [7:0] d;
  logic [3:0] n;
  logic bc;
  // accept after a short or long delay, answer queries unless muted
  initial begin
    tx_ready = 1'b0;
    rsp_valid = 1'b0;
    rsp_data = 8'h00;
    forever begin
      @(posedge clock);
      if (nrst && tx_valid) begin
        repeat (slow ? 3 : 0) @(posedge clock);
        tx_ready <= 1'b1;
        @(posedge clock);
        tx_ready <= 1'b0;
        d = tx_data;
        n = tx_node;
        bc = tx_bcast;
        if (!bc && !mute[n]) begin
          repeat (slow ? 4 : 1) @(posedge clock);
          rsp_valid <= 1'b1;
          rsp_data <= d ^ 8'ha5;
          @(posedge clock);
          rsp_valid <= 1'b0;
          rsp_data <= ~(d ^ 8'ha5); // released line shows no old value
        end
      end
    end
  end
endmodule // sqs_slave_model

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// scheduler bench
// ------------------------------------------------------------------
module tb;
  import sqs_pkg::*;
  logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, fb_online = 1, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rnd = 88552;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, tx_valid, tx_ready, tx_bcast, rsp_valid, subnet_offline, irq;
  logic [3:0] tx_node, mute = 0;
  logic [7:0] tx_data, rsp_data, host_data, out_data = 0, trig_byte = 0;
  logic [11:0] trig_addr;
  logic [11:0] q[$];
  logic last_bc = 0;
  int num_errors = 0, cmp_count = 0, cyc = 0, t1 = 0, tbc = 0, n_acc = 0, n1 = 0;
  sqs_sched #(.NODES(4), .DATA_W(8), .TICK_CYCLES(10)) uut (.clock, .nrst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .tx_valid, .tx_ready, .tx_node, .tx_bcast, .tx_data, .out_data, .rsp_valid, .rsp_data,
    .host_data, .fb_online, .subnet_offline, .trig_addr, .trig_byte, .irq);
  sqs_slave_model slave (.clock, .nrst, .tx_valid, .tx_node, .tx_bcast, .tx_data, .slow,
    .mute, .tx_ready, .rsp_valid, .rsp_data);
  // clock and run limit
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one single transfer, address then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check("register", r, exp);
  endtask
  task automatic cfg(input logic [31:0] ctl);
    wr(SQS_GAP_OFS, 32'h3);
    wr(SQS_TMO_OFS, 32'h3);
    wr(SQS_RETRY_OFS, 32'h2);
    wr(SQS_RECON_OFS, 32'h5);
    wr(SQS_MASK_OFS, 32'h3);
    wr(SQS_CTRL_OFS, 32'h2301 | ctl);
  endtask
  task automatic newrun(output logic [7:0] c);
    rnd = xs(rnd);
    c = rnd[7:0];
    out_data <= c;
    trig_byte <= rnd[15:8];
    mute <= 4'h0;
    fb_online <= 1'b1;
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
  endtask
  task automatic waitq();
    int i;
    for (i = 0; i < 3000 && q.size() > 0; i++) @(posedge clock);
    check("notes left", q.size(), 0);
  endtask
  // watch accepted offers against the oldest note and spacing
  always @(posedge clock) begin
    logic [11:0] e;
    if (nrst && tx_valid && tx_ready) begin
      n_acc++;
      if (tx_node == 4'h1 && mute[1]) check("retry spacing", cyc - t1 >= 20, 1);
      if (tx_node == 4'h1) begin
        t1 = cyc;
        n1++;
      end
      if (last_bc) check("bcast gap", cyc - tbc >= 20, 1);
      last_bc = tx_bcast;
      tbc = cyc;
      check("tx_bcast", tx_bcast, tx_node == 4'h2);
      if (q.size() > 0) begin
        e = q.pop_front();
        if (e[11:8] != 4'hf) check("tx_node", tx_node, e[11:8]);
        check("tx_data", tx_data, e[7:0]);
      end
    end
  end
  // main sequence
  initial begin
    logic [7:0] c;
    int pol, i, k;
    newrun(c);
    rd(SQS_CTRL_OFS, 32'h100);
    rd(SQS_GAP_OFS, 32'ha);
    rd(SQS_RETRY_OFS, 32'h3);
    rd(SQS_TADDR_OFS, 32'h200);
    rd(8'h40, 32'h0);
    rd(SQS_STATE_OFS, 32'h0);
    slow <= 1'b1;
    q = '{{4'h0, c}, {4'h1, c}, {4'h2, c}, {4'h0, c}};
    cfg(32'h0);
    waitq();
    repeat (10) @(posedge clock);
    check("host_data", host_data, c ^ 8'ha5);
    slow <= 1'b0;
    for (pol = 0; pol < 3; pol++) begin
      newrun(c);
      q = '{{4'h0, c}, {4'h1, c}};
      cfg(pol << 2);
      waitq();
      wr(SQS_CTRL_OFS, 32'h2300 | pol << 2);
      repeat (100) @(posedge clock);
      fb_online <= 1'b0;
      out_data <= ~c;
      k = n_acc;
      if (pol != 2) q = '{{4'hf, pol == 0 ? 8'h00 : c}, {4'hf, pol == 0 ? 8'h00 : c}};
      wr(SQS_CTRL_OFS, 32'h2301 | pol << 2);
      if (pol != 2) waitq();
      else begin
        repeat (300) @(posedge clock);
        check("halted offers", n_acc, k);
      end
    end
    for (pol = 0; pol < 2; pol++) begin
      newrun(c);
      q = '{{4'h0, c}, {4'h1, c}};
      cfg(pol << 4);
      waitq();
      repeat (10) @(posedge clock);
      k = n1;
      mute <= 4'h2;
      for (i = 0; i < 3000 && subnet_offline !== 1'b1; i++) @(posedge clock);
      check("tries to disconnect", n1 - k, 2);
      k = cyc;
      check("offline host_data", host_data, pol ? c ^ 8'ha5 : 8'h00);
      check("irq", irq, 1'b1);
      rd(SQS_STAT_OFS, 32'h3);
      check("irq", irq, 1'b0);
      mute <= 4'h0;
      for (i = 0; i < 3000 && subnet_offline !== 1'b0; i++) @(posedge clock);
      check("subnet_offline", subnet_offline, 1'b0);
      check("reconnect wait", cyc - k >= 40, 1);
      repeat (5) @(posedge clock);
      check("host_data", host_data, c ^ 8'ha5);
      // a cleared count needs the full number of tries again
      k = n1;
      mute <= 4'h2;
      for (i = 0; i < 3000 && subnet_offline !== 1'b1; i++) @(posedge clock);
      check("tries after reconnect", n1 - k, 2);
    end
    newrun(c);
    wr(SQS_TADDR_OFS, 32'h100);
    k = n_acc;
    cfg(32'h2);
    repeat (300) @(posedge clock);
    check("trig_addr", trig_addr, 32'h100);
    check("bad trigger offers", n_acc, k);
    check("irq masked", irq, 1'b0);
    rd(SQS_STAT_OFS, 32'h4);
    // fix the address first, so no pass can swallow the trigger change
    wr(SQS_TADDR_OFS, 32'h200);
    repeat (50) @(posedge clock);
    check("trig_addr", trig_addr, 32'h200);
    check("unchanged trigger offers", n_acc, k);
    q = '{{4'h0, c}};
    trig_byte <= ~trig_byte;
    waitq();
    end_of_test();
  end
endmodule // tb

bind sqs_sched sqs_sched_properties chk (.clock, .nrst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .tx_valid, .tx_ready, .tx_node, .tx_bcast, .tx_data,
  .rsp_valid, .host_data, .subnet_offline, .irq);

`default_nettype wire
